// ---- fds_counter.sv ----
module fds_counter #(
  parameter int CNT_W = 16
) (
  input wire logic clk_in, // processing clock
  input wire logic rst_in, // synchronous reset
  input wire logic clear_in, // hold at zero
  input wire logic hit_in, // count this cycle
  output logic [CNT_W-1:0] count_out // running count
);
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      count_out <= '0;
    end else if (hit_in) begin
      count_out <= count_out + 1'b1;
    end
  end
endmodule : fds_counter

// ---- fds_filter_debug_stats.sv ----
module fds_filter_debug_stats
  import fds_pkg::*;
#(
  parameter int ACC_W = 32,
  parameter int CNT_W = 16
) (
  input wire logic clk_in, // 50 MHz processing clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic [fds_pkg::ADDR_W-1:0] reg_addr_in, // register address
  input wire logic reg_wr_in, // write strobe
  input wire logic [fds_pkg::DATA_W-1:0] reg_wdata_in, // write data
  input wire logic reg_rd_in, // read strobe
  output logic [fds_pkg::DATA_W-1:0] reg_rdata_out, // read data, one cycle after strobe
  output logic [fds_pkg::ACC_ADDR_W-1:0] acc_addr_out, // accumulator address to filters
  output logic acc_group_out, // 0 pre-filter, 1 array filter
  input wire logic [ACC_W-1:0] pre_acc_data_in, // pre-filter accumulator at acc_addr_out
  input wire logic [ACC_W-1:0] array_acc_data_in, // array accumulator at acc_addr_out
  output logic [ACC_W-1:0] debug_acc_out, // selected accumulator, zero outside debug
  output logic debug_mode_out, // debug mode active
  input wire logic step_req_in, // one-cycle step request
  output logic filter_advance_out, // filter may advance this cycle
  input wire logic coef_req_in, // coefficient memory access request
  output logic coef_grant_out, // access granted
  output logic coef_refuse_out, // access refused
  input wire logic [1:0] sample_stb_in, // per stage: sample processed
  input wire logic [1:0] overflow_stb_in, // per stage: overflow event
  input wire logic [1:0] freq_err_stb_in, // per stage: frequency error event
  input wire logic [1:0][fds_pkg::CHAN_W-1:0] event_chan_in, // per stage: channel of event
  input wire logic [1:0][fds_pkg::MAG_W-1:0] sample_magnitude_bits_in, // per stage magnitude
  output logic [1:0][CNT_W-1:0] first_count_out, // per stage counter one
  output logic [1:0][CNT_W-1:0] second_count_out // per stage counter two
);
  import fds_pkg::*;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic [DATA_W-1:0] filter_debug_control;
  logic [DATA_W-1:0] filter_statistics_control;
  logic [1:0] stage_clear;
  logic [1:0] chan_match;
  logic [1:0] first_hit;
  logic [1:0] second_hit;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      filter_debug_control <= DEBUG_CTRL_RESET;
      filter_statistics_control <= STAT_CTRL_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_DEBUG_CTRL) begin
        filter_debug_control <= reg_wdata_in & DEBUG_CTRL_MASK;
      end
      if (reg_addr_in == REG_STAT_CTRL) begin
        filter_statistics_control <= reg_wdata_in & STAT_CTRL_MASK;
      end
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      if (reg_addr_in == REG_DEBUG_CTRL) begin
        reg_rdata_out <= filter_debug_control;
      end else if (reg_addr_in == REG_STAT_CTRL) begin
        reg_rdata_out <= filter_statistics_control;
      end else begin
        reg_rdata_out <= '0;
      end
    end
  end

  assign debug_mode_out = filter_debug_control[DEBUG_BIT];
  assign acc_addr_out = filter_debug_control[ACC_ADDR_LSB +: ACC_ADDR_W];
  assign acc_group_out = filter_debug_control[GROUP_BIT];

  // accumulator is captured only in debug mode so normal running shows nothing
  always_ff @(posedge clk_in) begin
    if (rst_in || !debug_mode_out) begin
      debug_acc_out <= '0;
    end else if (acc_group_out) begin
      debug_acc_out <= array_acc_data_in;
    end else begin
      debug_acc_out <= pre_acc_data_in;
    end
  end

  // single step gates the filter to one advance per request
  assign filter_advance_out = filter_debug_control[STEP_BIT] ? step_req_in : 1'b1;
  assign coef_grant_out = coef_req_in & debug_mode_out;
  assign coef_refuse_out = coef_req_in & ~debug_mode_out;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_stage
      localparam int B = s * STAGE_STRIDE;
      // channel codes 8..15 match no channel, so nothing counts
      assign chan_match[s] = filter_statistics_control[B + CHAN_LSB +: FIELD_W]
                             == {1'b0, event_chan_in[s]};
      assign stage_clear[s] = filter_statistics_control[B + CLEAR_BIT];
      assign first_hit[s] = chan_match[s] & fds_source_hit(
          filter_statistics_control[B + SRC1_LSB +: FIELD_W], sample_stb_in[s],
          overflow_stb_in[s], freq_err_stb_in[s], sample_magnitude_bits_in[s]);
      assign second_hit[s] = chan_match[s] & fds_source_hit(
          filter_statistics_control[B + SRC2_LSB +: FIELD_W], sample_stb_in[s],
          overflow_stb_in[s], freq_err_stb_in[s], sample_magnitude_bits_in[s]);
      fds_counter #(.CNT_W(CNT_W)) u_first (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(stage_clear[s]),
        .hit_in(first_hit[s]),
        .count_out(first_count_out[s])
      );
      fds_counter #(.CNT_W(CNT_W)) u_second (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(stage_clear[s]),
        .hit_in(second_hit[s]),
        .count_out(second_count_out[s])
      );
    end
  endgenerate

  logic [FIELD_W-1:0] pre_src1;
  logic [FIELD_W-1:0] pre_src2;
  logic pre_match;
  logic [FIELD_W-1:0] arr_src1;
  assign pre_src1 = filter_statistics_control[SRC1_LSB +: FIELD_W];
  assign pre_src2 = filter_statistics_control[SRC2_LSB +: FIELD_W];
  assign pre_match = filter_statistics_control[CHAN_LSB +: FIELD_W] == {1'b0, event_chan_in[0]};
  assign arr_src1 = filter_statistics_control[STAGE_STRIDE + SRC1_LSB +: FIELD_W];

  property p_acc_addr;
    reg_wr_in && reg_addr_in == REG_DEBUG_CTRL
      |=> acc_addr_out == $past(reg_wdata_in[ACC_ADDR_LSB +: ACC_ADDR_W]);
  endproperty
  a_acc_addr: assert property (p_acc_addr) else $error("accumulator address not from register");

  property p_acc_hold;
    !(reg_wr_in && reg_addr_in == REG_DEBUG_CTRL) |=> $stable(acc_addr_out);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator address moved without write");

  property p_debug_zero;
    !debug_mode_out |=> debug_acc_out == '0;
  endproperty
  a_debug_zero: assert property (p_debug_zero) else $error("accumulator shown outside debug");

  property p_acc_group;
    debug_mode_out && !acc_group_out |=> $past(debug_mode_out) && debug_acc_out == $past(pre_acc_data_in);
  endproperty
  a_acc_group: assert property (p_acc_group) else $error("pre-filter accumulator not shown");

  property p_acc_array;
    debug_mode_out && acc_group_out |=> debug_acc_out == $past(array_acc_data_in);
  endproperty
  a_acc_array: assert property (p_acc_array) else $error("array accumulator not shown");

  property p_coef;
    coef_req_in |-> (coef_grant_out == debug_mode_out) && (coef_refuse_out != debug_mode_out);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient access decision wrong");

  property p_step;
    filter_debug_control[STEP_BIT] && !step_req_in |-> !filter_advance_out;
  endproperty
  a_step: assert property (p_step) else $error("filter advanced without step request");

  property p_free_run;
    !filter_debug_control[STEP_BIT] |-> filter_advance_out;
  endproperty
  a_free_run: assert property (p_free_run) else $error("filter held with single step off");

  property p_stat_write;
    reg_wr_in && reg_addr_in == REG_STAT_CTRL
      |=> filter_statistics_control == ($past(reg_wdata_in) & STAT_CTRL_MASK);
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("statistics control not written");

  property p_sample_count;
    pre_src1 == SRC_SAMPLE && sample_stb_in[0] && pre_match && !stage_clear[0]
      |=> first_count_out[0] == $past(first_count_out[0]) + 1'b1;
  endproperty
  a_sample_count: assert property (p_sample_count) else $error("sample not counted");

  property p_overflow_count;
    pre_src2 == SRC_OVERFLOW && pre_match && !stage_clear[0]
      |=> second_count_out[0] == $past(second_count_out[0]) + $past(overflow_stb_in[0]);
  endproperty
  a_overflow_count: assert property (p_overflow_count) else $error("overflow count wrong");

  property p_ferr_count;
    pre_src1 == SRC_FREQ_ERR && pre_match && !stage_clear[0]
      |=> first_count_out[0] == $past(first_count_out[0]) + $past(freq_err_stb_in[0]);
  endproperty
  a_ferr_count: assert property (p_ferr_count) else $error("frequency error count wrong");

  property p_chan_gate;
    !pre_match && !stage_clear[0] |=> $stable(first_count_out[0]) && $stable(second_count_out[0]);
  endproperty
  a_chan_gate: assert property (p_chan_gate) else $error("other channel counted");

  property p_mag_top;
    pre_src2 == 4'h8 && pre_match && !stage_clear[0] && sample_stb_in[0]
      |=> second_count_out[0] == $past(second_count_out[0]) + $past(sample_magnitude_bits_in[0][MAG_W-1]);
  endproperty
  a_mag_top: assert property (p_mag_top) else $error("magnitude count wrong");

  property p_clear;
    stage_clear[1] [*2] |-> first_count_out[1] == '0 && second_count_out[1] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("cleared counters not zero");

  property p_clear_pre;
    stage_clear[0] |=> first_count_out[0] == '0 && second_count_out[0] == '0;
  endproperty
  a_clear_pre: assert property (p_clear_pre) else $error("cleared pre-filter counters not zero");

  // codes 3..7 name no source, so the counter must sit still
  property p_src_none;
    !arr_src1[SRC_MAG_BIT] && arr_src1 > SRC_FREQ_ERR && !stage_clear[1] |=> $stable(first_count_out[1]);
  endproperty
  a_src_none: assert property (p_src_none) else $error("unused mode code counted");

  c_debug_read: cover property (debug_mode_out && acc_group_out ##1 debug_mode_out);
  c_step: cover property (filter_debug_control[STEP_BIT] && step_req_in);
  c_refuse: cover property (coef_refuse_out);
  c_count: cover property (first_hit[1] ##1 second_hit[0]);
  c_mag: cover property (second_hit[0] && pre_src2[SRC_MAG_BIT]);
endmodule : fds_filter_debug_stats

// ---- fds_pkg.sv ----
package fds_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_DEBUG_CTRL = 12'h504;
  localparam logic [ADDR_W-1:0] REG_STAT_CTRL = 12'h505;
  localparam logic [DATA_W-1:0] DEBUG_CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STAT_CTRL_RESET = 32'h0000_0000;
  // unused bits read as zero
  localparam logic [DATA_W-1:0] DEBUG_CTRL_MASK = 32'h0000_00DF;
  localparam logic [DATA_W-1:0] STAT_CTRL_MASK = 32'h8FFF_8FFF;
  localparam int ACC_ADDR_LSB = 0;
  localparam int ACC_ADDR_W = 4;
  localparam int GROUP_BIT = 4;
  localparam int STEP_BIT = 6;
  localparam int DEBUG_BIT = 7;
  localparam int STAGE_STRIDE = 16;
  localparam int CHAN_LSB = 0;
  localparam int SRC1_LSB = 4;
  localparam int SRC2_LSB = 8;
  localparam int FIELD_W = 4;
  localparam int CLEAR_BIT = 15;
  localparam int MAG_W = 8;
  localparam int CHAN_W = 3;
  localparam logic [FIELD_W-1:0] SRC_SAMPLE = 4'h0;
  localparam logic [FIELD_W-1:0] SRC_OVERFLOW = 4'h1;
  localparam logic [FIELD_W-1:0] SRC_FREQ_ERR = 4'h2;
  localparam int SRC_MAG_BIT = 3;

  // magnitude codes 1000..1111 watch bits 7 down to 7-k; any set bit counts
  function automatic logic fds_source_hit(input logic [FIELD_W-1:0] src, input logic sample,
                                          input logic ovf, input logic ferr,
                                          input logic [MAG_W-1:0] mag);
    logic [MAG_W-1:0] mask;
    logic hit;
    mask = ~(8'hFF >> ({1'b0, src[2:0]} + 4'h1));
    hit = 1'b0;
    if (src[SRC_MAG_BIT]) begin
      hit = sample & (|(mag & mask));
    end else if (src == SRC_SAMPLE) begin
      hit = sample;
    end else if (src == SRC_OVERFLOW) begin
      hit = ovf;
    end else if (src == SRC_FREQ_ERR) begin
      hit = ferr;
    end
    return hit;
  endfunction : fds_source_hit
endpackage : fds_pkg

// ---- tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fds_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [ACC_ADDR_W-1:0] acc_addr;
  logic acc_group;
  logic [31:0] pre_acc = 32'h1234_5678;
  logic [31:0] array_acc = 32'h9ABC_DEF0;
  logic [31:0] debug_acc;
  logic debug_mode;
  logic step_req = 1'b0;
  logic advance;
  logic coef_req = 1'b0;
  logic grant;
  logic refuse;
  logic [1:0] smp = '0;
  logic [1:0] ovf = '0;
  logic [1:0] ferr = '0;
  logic [1:0][CHAN_W-1:0] chan = '0;
  logic [1:0][MAG_W-1:0] mag = '0;
  logic [1:0][15:0] cnt1;
  logic [1:0][15:0] cnt2;
  logic [15:0] e1;
  logic [15:0] e2;
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 clk_in = ~clk_in;

  fds_filter_debug_stats i_fds_filter_debug_stats (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr_stb), .reg_wdata_in(wdata), .reg_rd_in(rd_stb), .reg_rdata_out(rdata),
    .acc_addr_out(acc_addr), .acc_group_out(acc_group), .pre_acc_data_in(pre_acc),
    .array_acc_data_in(array_acc), .debug_acc_out(debug_acc), .debug_mode_out(debug_mode),
    .step_req_in(step_req), .filter_advance_out(advance), .coef_req_in(coef_req), .coef_grant_out(grant),
    .coef_refuse_out(refuse), .sample_stb_in(smp), .overflow_stb_in(ovf), .freq_err_stb_in(ferr),
    .event_chan_in(chan), .sample_magnitude_bits_in(mag), .first_count_out(cnt1), .second_count_out(cnt2));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // all tasks start and end one small delay after a rising edge
  // an idle edge follows each transfer so no strobe drops and rises in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(posedge clk_in);
    #1 wr_stb = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string name);
    addr = a;
    rd_stb = 1'b1;
    @(posedge clk_in);
    #1 rd_stb = 1'b0;
    chk(name, exp, rdata);
    @(posedge clk_in);
    #1;
  endtask : rd

  // same channel and magnitude on both stages keeps the call short
  task automatic pulse(input logic [1:0] s, input logic [1:0] o, input logic [1:0] f,
                       input logic [2:0] c, input logic [7:0] m);
    smp = s;
    ovf = o;
    ferr = f;
    chan = {c, c};
    mag = {m, m};
    @(posedge clk_in);
    #1 smp = '0;
    ovf = '0;
    ferr = '0;
    @(posedge clk_in);
    #1;
  endtask : pulse

  task automatic cnt(input logic [15:0] a0, input logic [15:0] b0, input logic [15:0] a1, input logic [15:0] b1);
    chk("first0", {16'h0000, a0}, {16'h0000, cnt1[0]});
    chk("second0", {16'h0000, b0}, {16'h0000, cnt2[0]});
    chk("first1", {16'h0000, a1}, {16'h0000, cnt1[1]});
    chk("second1", {16'h0000, b1}, {16'h0000, cnt2[1]});
  endtask : cnt

  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    #1 rst_in = 1'b0;
    rd(REG_DEBUG_CTRL, DEBUG_CTRL_RESET, "debug ctrl reset");
    rd(REG_STAT_CTRL, STAT_CTRL_RESET, "stat ctrl reset");
    wr(REG_DEBUG_CTRL, 32'hFFFF_FFFF);
    rd(REG_DEBUG_CTRL, 32'h0000_00DF, "debug ctrl mask");
    wr(12'h506, 32'hFFFF_FFFF);
    rd(12'h506, 32'h0000_0000, "unmapped");
    rd(REG_STAT_CTRL, 32'h0000_0000, "stat ctrl untouched");
    wr(REG_DEBUG_CTRL, 32'h0000_0095);
    chk("acc addr", 32'h5, {28'h0, acc_addr});
    chk("acc group", 32'h1, {31'h0, acc_group});
    chk("debug mode on", 32'h1, {31'h0, debug_mode});
    @(posedge clk_in);
    #1 chk("array acc", array_acc, debug_acc);
    coef_req = 1'b1;
    #1 chk("grant on", 32'h1, {31'h0, grant});
    chk("refuse on", 32'h0, {31'h0, refuse});
    @(posedge clk_in);
    #1 wr(REG_DEBUG_CTRL, 32'h0000_0085);
    @(posedge clk_in);
    #1 chk("pre acc", pre_acc, debug_acc);
    wr(REG_DEBUG_CTRL, 32'h0000_00C5);
    chk("advance no step", 32'h0, {31'h0, advance});
    step_req = 1'b1;
    #1 chk("advance step", 32'h1, {31'h0, advance});
    @(posedge clk_in);
    #1 step_req = 1'b0;
    wr(REG_DEBUG_CTRL, 32'h0000_0005);
    @(posedge clk_in);
    #1 chk("acc outside debug", 32'h0, debug_acc);
    chk("debug mode off", 32'h0, {31'h0, debug_mode});
    chk("refuse off", 32'h1, {31'h0, refuse});
    chk("grant off", 32'h0, {31'h0, grant});
    chk("advance free", 32'h1, {31'h0, advance});
    coef_req = 1'b0;
    // pre stage: counter one overflow, counter two sample; array: freq error, top magnitude bit
    wr(REG_STAT_CTRL, 32'h0823_0013);
    rd(REG_STAT_CTRL, 32'h0823_0013, "stat ctrl");
    pulse(2'b11, 2'b00, 2'b00, 3'h3, 8'h80);
    cnt(16'h0, 16'h1, 16'h0, 16'h1);
    pulse(2'b00, 2'b11, 2'b11, 3'h3, 8'h00);
    cnt(16'h1, 16'h1, 16'h1, 16'h1);
    pulse(2'b11, 2'b11, 2'b11, 3'h2, 8'hFF);
    cnt(16'h1, 16'h1, 16'h1, 16'h1);
    // pre stage: frequency error and overflow; array codes 3 and 7 count nothing
    wr(REG_STAT_CTRL, 32'h0733_0123);
    pulse(2'b11, 2'b11, 2'b11, 3'h3, 8'hFF);
    cnt(16'h2, 16'h2, 16'h1, 16'h1);
    wr(REG_STAT_CTRL, 32'h8000_8000);
    pulse(2'b11, 2'b11, 2'b11, 3'h0, 8'hFF);
    cnt(16'h0, 16'h0, 16'h0, 16'h0);
    e1 = 16'h0;
    e2 = 16'h0;
    // each magnitude code: lowest watched bit hits, the bit below it does not
    for (int k = 0; k < 8; k++) begin
      wr(REG_STAT_CTRL, {16'h0000, 4'h0, 4'(8 + k), 8'h00});
      pulse(2'b01, 2'b00, 2'b00, 3'h0, 8'(8'h80 >> k));
      pulse(2'b01, 2'b00, 2'b00, 3'h0, 8'(8'h80 >> (k + 1)));
      e1 = e1 + 16'h2;
      e2 = e2 + 16'h1;
      cnt(e1, e2, 16'h0, 16'h0);
    end
    finish_test();
  end
endmodule : tb
